// ===== phy_regs_pkg.sv
// Constants and types for the PHY status and 10 Mb/s operations registers
package phy_regs_pkg;

  // ***********************************************************
  // Register addresses on the management port
  // ***********************************************************
  localparam logic [4:0]  ADDR_XSTAT   = 5'h11;   // Extended receive status
  localparam logic [4:0]  ADDR_TENOP   = 5'h12;   // 10 Mb/s operations

  // ***********************************************************
  // Extended receive status bit positions
  // ***********************************************************
  localparam int XS_PLL  = 9;
  localparam int XS_FC   = 8;
  localparam int XS_INV  = 7;
  localparam int XS_HALT = 6;
  localparam int XS_PEND = 5;
  localparam int XS_ANC  = 4;
  localparam int XS_SD   = 3;
  localparam int XS_JAB  = 2;
  localparam int XS_RF   = 1;
  localparam int XS_LINK = 0;

  // ***********************************************************
  // 10 Mb/s operations bit positions and reset value
  // ***********************************************************
  localparam int TO_RJAB  = 15;
  localparam int TO_POL   = 14;
  localparam int TO_JINH  = 5;
  localparam int TO_APINH = 3;
  localparam int TO_SQE   = 2;
  localparam int TO_LLINH = 1;
  localparam int TO_SQINH = 0;
  localparam logic [15:0] TENOP_RESET = 16'h0010;  // Reserved bit 4 is one
  localparam logic [15:0] TENOP_WMASK = 16'h3FFF;  // Bits 13..0 hold writes

  // ***********************************************************
  // 5-bit code groups of the 100 Mb/s stream
  // ***********************************************************
  localparam logic [4:0]  SYM_IDLE = 5'h1F;
  localparam logic [4:0]  SYM_J    = 5'h18;
  localparam logic [4:0]  SYM_K    = 5'h11;
  localparam logic [4:0]  SYM_T    = 5'h0D;
  localparam logic [4:0]  SYM_R    = 5'h07;
  localparam logic [4:0]  SYM_HALT = 5'h04;

  // ***********************************************************
  // Jabber timing
  // ***********************************************************
  localparam int JABBER_MS = 20;                        // Least jabber time
  localparam int CLK_MHZ   = 250;                       // Core clock rate
  localparam int JABBER_CYC = JABBER_MS * CLK_MHZ * 1000;

  // Receive symbol tracker states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SSD  = 2'b01,
    RX_PKT  = 2'b10,
    RX_END  = 2'b11
  } rx_state_t;

  // True for the sixteen data code groups
  function automatic logic is_data_sym(input logic [4:0] s);
    case (s)
      5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D: is_data_sym = 1'b1;
      default: is_data_sym = 1'b0;
    endcase
  endfunction

endpackage

// ===== activity_timer.sv
// Counts continuous activity and flags when it lasts past a limit
`timescale 1ns/10ps
module activity_timer
  import phy_regs_pkg::*;
#(
  parameter int unsigned LIMIT = JABBER_CYC
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Activity in, expiry out
  input  wire logic active_in,
  output logic      expired_out
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_q;  // Cycles of unbroken activity

  // ***********************************************************
  // Counter: saturates so a long burst keeps the flag up
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !active_in) begin
      cnt_q <= '0;
    end else if (cnt_q != LIM) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Flag stands until activity drops
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !active_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= (cnt_q == LIM);
    end
  end

endmodule // activity_timer

// ===== rx_symbol_check.sv
// Tracks the 100 Mb/s code-group stream and reports receive errors
`timescale 1ns/10ps
module rx_symbol_check
  import phy_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Aligned code groups
  input  wire logic       sym_valid_in,
  input  wire logic [4:0] sym_in,
  // One-cycle event pulses
  output logic            false_carrier_out,
  output logic            invalid_out,
  output logic            halt_out,
  output logic            prem_end_out,
  // Receive error toward the MAC
  output logic            rx_err_out
);

  rx_state_t state_q;     // Frame position
  logic      prev_idle_q; // Last in-packet group was idle

  // ***********************************************************
  // Frame tracker
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_q     <= RX_IDLE;
      prev_idle_q <= 1'b0;
    end else if (sym_valid_in) begin
      unique case (state_q)
        RX_IDLE: begin
          // Only J starts the delimiter check; other non-idle is false carrier
          if (sym_in == SYM_J) begin
            state_q <= RX_SSD;
          end
        end
        RX_SSD: begin
          prev_idle_q <= 1'b0;
          state_q     <= (sym_in == SYM_K) ? RX_PKT : RX_IDLE;
        end
        RX_PKT: begin
          if (sym_in == SYM_IDLE) begin
            prev_idle_q <= 1'b1;
            // Second idle ends the frame early
            if (prev_idle_q) begin
              state_q <= RX_IDLE;
            end
          end else begin
            prev_idle_q <= 1'b0;
            if (sym_in == SYM_T) begin
              state_q <= RX_END;
            end
          end
        end
        RX_END: begin
          state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************
  // Event pulses, one cycle after the offending group
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      false_carrier_out <= 1'b0;
      invalid_out       <= 1'b0;
      halt_out          <= 1'b0;
      prem_end_out      <= 1'b0;
      rx_err_out        <= 1'b0;
    end else begin
      false_carrier_out <= sym_valid_in &&                                          // [RULE2]
        ((state_q == RX_IDLE && sym_in != SYM_IDLE && sym_in != SYM_J) ||
         (state_q == RX_SSD && sym_in != SYM_K));
      invalid_out <= sym_valid_in && (                                              // [RULE3]
        (state_q == RX_PKT && !is_data_sym(sym_in) && sym_in != SYM_IDLE &&
         sym_in != SYM_T && sym_in != SYM_HALT) ||
        (state_q == RX_END && sym_in != SYM_R));
      halt_out     <= sym_valid_in && state_q == RX_PKT && sym_in == SYM_HALT;      // [RULE4]
      prem_end_out <= sym_valid_in && state_q == RX_PKT && sym_in == SYM_IDLE
                      && prev_idle_q;                                                // [RULE5]
      // Invalid and halt groups both reach the MAC as an error
      rx_err_out <= sym_valid_in && (
        (state_q == RX_PKT && !is_data_sym(sym_in) && sym_in != SYM_IDLE &&
         sym_in != SYM_T) ||
        (state_q == RX_END && sym_in != SYM_R));                                    // [RULE3] [RULE4]
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_halt_err;
    @(posedge core_clk_in) disable iff (rst_in)
    sym_valid_in && state_q == RX_PKT && sym_in == SYM_HALT |=> halt_out && rx_err_out;
  endproperty
  a_halt_err: assert property (p_halt_err) else $error("halt group not reported"); // [RULE4]

endmodule // rx_symbol_check

// ===== phy_status_regs.sv
// Extended receive status and 10 Mb/s operations registers of the PHY
//
// What this block does
// RULE1: Latch PLL lock failure until read or reset
// RULE2: Latch false carrier on bad start delimiter
// RULE3: Invalid symbol raises RX error and flag
// RULE4: Halt code in packet signalled and flagged
// RULE5: Two idles inside packet flag premature end
// RULE6: Sticky flags hold until read, then clear
// RULE7: 100M error flags meaningless at 10 Mb/s
// RULE8: Negotiation complete only when enabled and finished
// RULE9: Signal detect is a live value
// RULE10: Jabber bit acts as basic jabber bit
// RULE11: Remote fault bit mirrors basic one
// RULE12: Link bit mirrors basic, latching low
// RULE13: Software writes reserved defaults on writes
// RULE14: Remote jabber latches, cleared by read, reset
// RULE15: Remote jabber from receive timing, informational
// RULE16: Polarity flag shows reversed receive pair
// RULE17: Jabber inhibit skips the transmit check
// RULE18: Auto-polarity inhibit stops polarity correction
// RULE19: SQE inhibit stops post-transmit test pulse
// RULE20: Link-loss inhibit forces link passed state
// RULE21: Squelch inhibit demands data then idle
// RULE22: Read returns pre-clear value, same-cycle set kept
`timescale 1ns/10ps
module phy_status_regs
  import phy_regs_pkg::*;
#(
  parameter int unsigned JABBER_CYCLES = JABBER_CYC  // Shorten in simulation
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Management register port
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  output logic             reg_rvalid_out,
  // 100 Mb/s receive path
  input  wire logic        sym_valid_in,
  input  wire logic [4:0]  sym_in,
  input  wire logic        pll_lock_fail_in,
  input  wire logic        sig_detect_in,
  output logic             rx_err_out,
  // Negotiation and basic status
  input  wire logic        an_enable_in,
  input  wire logic        an_done_in,
  input  wire logic        remote_fault_in,
  input  wire logic        link_ok_in,
  // 10 Mb/s path
  input  wire logic        tx_en_in,
  input  wire logic        rx10_active_in,
  input  wire logic        pol_reversed_in,
  output logic             jabber_out,
  output logic             pol_correct_out,
  output logic             sqe_inhibit_out,
  output logic             link_force_pass_out,
  output logic             squelch_inhibit_out
);

  // ***********************************************************
  // Declarations
  // ***********************************************************
  logic        fc_evt;        // False carrier pulse
  logic        inv_evt;       // Invalid symbol pulse
  logic        halt_evt;      // Halt symbol pulse
  logic        pend_evt;      // Premature end pulse
  logic        tx_jab_exp;    // Transmit ran too long
  logic        rx_jab_exp;    // Receive ran too long
  logic        rd_xs;         // Read of extended status
  logic        rd_to;         // Read of operations register
  logic        wr_to;         // Write of operations register
  logic        jab_evt;       // Local jabber seen, check enabled
  logic        pll_q;
  logic        fc_q;
  logic        inv_q;
  logic        halt_q;
  logic        pend_q;
  logic        jab_q;
  logic        rf_q;
  logic        link_q;        // Latching-low link status
  logic        rjab_q;
  logic        pol_q;
  logic [15:0] tenop_q;       // Writable bits of operations register
  logic [15:0] xs_val;        // Extended status as read
  logic [15:0] to_val;        // Operations register as read

  // Sticky update: a set in the clearing cycle wins
  function automatic logic sticky(input logic q, input logic set, input logic clr);
    sticky = set | (q & ~clr);
  endfunction

  // ***********************************************************
  // Sub-blocks
  // ***********************************************************
  rx_symbol_check u_rxchk (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .sym_valid_in      (sym_valid_in),
    .sym_in            (sym_in),
    .false_carrier_out (fc_evt),
    .invalid_out       (inv_evt),
    .halt_out          (halt_evt),
    .prem_end_out      (pend_evt),
    .rx_err_out        (rx_err_out)
  );

  // Local transmit jabber watch
  activity_timer #(.LIMIT(JABBER_CYCLES)) u_txjab (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .active_in   (tx_en_in),
    .expired_out (tx_jab_exp)
  );

  // Same criteria applied to the receive path
  activity_timer #(.LIMIT(JABBER_CYCLES)) u_rxjab (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .active_in   (rx10_active_in),
    .expired_out (rx_jab_exp)                                    // [RULE15]
  );

  // ***********************************************************
  // Address decode
  // ***********************************************************
  assign rd_xs   = reg_rd_in && reg_addr_in == ADDR_XSTAT;
  assign rd_to   = reg_rd_in && reg_addr_in == ADDR_TENOP;
  assign wr_to   = reg_wr_in && reg_addr_in == ADDR_TENOP;
  assign jab_evt = tx_jab_exp && !tenop_q[TO_JINH];                // [RULE17]

  // ***********************************************************
  // 100 Mb/s error flags; they still latch at 10 Mb/s, where
  // their value carries no meaning and software ignores them
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pll_q  <= 1'b0;
      fc_q   <= 1'b0;
      inv_q  <= 1'b0;
      halt_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      pll_q  <= sticky(pll_q, pll_lock_fail_in, rd_xs);          // [RULE1] [RULE6] [RULE7]
      fc_q   <= sticky(fc_q, fc_evt, rd_xs);                     // [RULE2] [RULE6]
      inv_q  <= sticky(inv_q, inv_evt, rd_xs);                   // [RULE3] [RULE6]
      halt_q <= sticky(halt_q, halt_evt, rd_xs);                 // [RULE4] [RULE6]
      pend_q <= sticky(pend_q, pend_evt, rd_xs);                 // [RULE5] [RULE22]
    end
  end

  // ***********************************************************
  // Mirrors of basic status bits, with their own latches
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      jab_q  <= 1'b0;
      rf_q   <= 1'b0;
      link_q <= 1'b0;
    end else begin
      jab_q <= sticky(jab_q, jab_evt, rd_xs);                    // [RULE10]
      rf_q  <= sticky(rf_q, remote_fault_in, rd_xs);             // [RULE11]
      // Low latches; a read re-arms from the present link state
      link_q <= rd_xs ? link_ok_in : (link_q & link_ok_in);      // [RULE12]
    end
  end

  // ***********************************************************
  // 10 Mb/s status flags
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rjab_q <= 1'b0;
      pol_q  <= 1'b0;
    end else begin
      // Informational only: drives nothing but the register
      rjab_q <= sticky(rjab_q, rx_jab_exp, rd_to);               // [RULE14] [RULE15]
      pol_q  <= sticky(pol_q, pol_reversed_in, rd_to);           // [RULE16]
    end
  end

  // ***********************************************************
  // Operations control bits; reserved bits keep what software
  // wrote, which is meant to be their defaults
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tenop_q <= TENOP_RESET;
    end else if (wr_to) begin
      tenop_q <= reg_wdata_in & TENOP_WMASK;                     // [RULE13]
    end
  end

  // ***********************************************************
  // Read data, captured before the clear takes effect
  // ***********************************************************
  always_comb begin
    xs_val          = '0;
    xs_val[XS_PLL]  = pll_q;
    xs_val[XS_FC]   = fc_q;
    xs_val[XS_INV]  = inv_q;
    xs_val[XS_HALT] = halt_q;
    xs_val[XS_PEND] = pend_q;
    xs_val[XS_ANC]  = an_enable_in && an_done_in;                // [RULE8]
    xs_val[XS_SD]   = sig_detect_in;                             // [RULE9]
    xs_val[XS_JAB]  = jab_q;
    xs_val[XS_RF]   = rf_q;
    xs_val[XS_LINK] = link_q;
    to_val          = tenop_q;
    to_val[TO_RJAB] = rjab_q;
    to_val[TO_POL]  = pol_q;
  end

  // Data stands until the next read; unmapped reads give zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out  <= '0;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_xs ? xs_val : (rd_to ? to_val : '0);  // [RULE22]
      end
    end
  end

  // ***********************************************************
  // Controls toward the 10 Mb/s logic
  // ***********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      jabber_out          <= 1'b0;
      pol_correct_out     <= 1'b0;
      sqe_inhibit_out     <= 1'b0;
      link_force_pass_out <= 1'b0;
      squelch_inhibit_out <= 1'b0;
    end else begin
      jabber_out          <= jab_evt;                                 // [RULE17]
      pol_correct_out     <= pol_reversed_in && !tenop_q[TO_APINH];   // [RULE18]
      sqe_inhibit_out     <= tenop_q[TO_SQE];                         // [RULE19]
      link_force_pass_out <= tenop_q[TO_LLINH];                       // [RULE20]
      squelch_inhibit_out <= tenop_q[TO_SQINH];                       // [RULE21]
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_pll_then_read;
    pll_lock_fail_in ##1 rd_xs;
  endsequence

  property p_pll_seen;
    s_pll_then_read |=> reg_rdata_out[XS_PLL];
  endproperty
  a_pll_seen: assert property (p_pll_seen) else $error("pll error lost before read"); // [RULE1]

  property p_fc_set;
    fc_evt |=> fc_q;
  endproperty
  a_fc_set: assert property (p_fc_set) else $error("false carrier not latched"); // [RULE2]

  property p_read_clears;
    rd_xs && !inv_evt ##1 !inv_evt |=> !inv_q;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("invalid flag not cleared"); // [RULE6]

  property p_set_wins;
    rd_xs && pll_lock_fail_in |=> pll_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in clear cycle"); // [RULE22]

  property p_preclear;
    rd_xs |=> reg_rvalid_out && reg_rdata_out[XS_PEND] == $past(pend_q);
  endproperty
  a_preclear: assert property (p_preclear) else $error("read lost pre-clear value"); // [RULE22]

  property p_anc;
    rd_xs && !an_enable_in |=> !reg_rdata_out[XS_ANC];
  endproperty
  a_anc: assert property (p_anc) else $error("complete while disabled"); // [RULE8]

  property p_sd;
    rd_xs |=> reg_rdata_out[XS_SD] == $past(sig_detect_in);
  endproperty
  a_sd: assert property (p_sd) else $error("signal detect not live"); // [RULE9]

  property p_link_low;
    !link_ok_in ##1 !rd_xs [*2] |=> !link_q;
  endproperty
  a_link_low: assert property (p_link_low) else $error("link loss not latched"); // [RULE12]

  property p_rjab_clear;
    rd_to && !rx_jab_exp ##1 !rx_jab_exp |=> !rjab_q;
  endproperty
  a_rjab_clear: assert property (p_rjab_clear) else $error("remote jabber not cleared"); // [RULE14]

  property p_jab_inh;
    tenop_q[TO_JINH] |=> !jabber_out;
  endproperty
  a_jab_inh: assert property (p_jab_inh) else $error("jabber despite inhibit"); // [RULE17]

  property p_llinh;
    wr_to && reg_wdata_in[TO_LLINH] ##1 !wr_to |=> link_force_pass_out;
  endproperty
  a_llinh: assert property (p_llinh) else $error("link pass not forced"); // [RULE20]

endmodule // phy_status_regs

// ===== mgmt_model.sv
// Management entity model driving the PHY register port
`timescale 1ns/10ps
module mgmt_model (
  // Clock
  input  wire logic        core_clk_in,
  // Register port toward the PHY
  output logic      [4:0]  reg_addr_out  = 5'h00,
  output logic             reg_wr_out    = 1'h0,
  output logic             reg_rd_out    = 1'h0,
  output logic      [15:0] reg_wdata_out = 16'h0000,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in
);
  // One write strobe; ops reserved bits always get their defaults
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == 5'h12) ? ((d & ~16'h3FC0) | 16'h0010) : d;
    @(posedge core_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= v;
    reg_wr_out    <= 1'h1;
    @(posedge core_clk_in);
    reg_wr_out    <= 1'h0;
    reg_wdata_out <= ~v;  // Released data must not look stale
  endtask
  // One read strobe; data only counts with the valid pulse
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'h1;
    @(posedge core_clk_in);
    reg_rd_out   <= 1'h0;
    @(negedge core_clk_in);
    d = (reg_rvalid_in === 1'h1) ? reg_rdata_in : 16'hXXXX;
    // Hand back on a rising edge so callers drive on that edge
    @(posedge core_clk_in);
  endtask
endmodule // mgmt_model

// ===== phy_status_regs_bench.sv
// Self-checking bench for the PHY status and 10 Mb/s operations registers
`timescale 1ns/10ps
module phy_status_regs_bench
  import phy_regs_pkg::*;
;
  // Symbol rows: four groups, PLL failure, expected status, RX error
  typedef struct packed {
    logic [19:0] s;
    logic        pll;
    logic [15:0] x;
    logic        e;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{{SYM_J, SYM_K, SYM_HALT, SYM_IDLE}, 1'h0, 16'h0040, 1'h1},
    '{{SYM_IDLE, 5'h0E, SYM_IDLE, SYM_IDLE}, 1'h0, 16'h0100, 1'h0},
    '{{SYM_J, 5'h0E, SYM_IDLE, SYM_IDLE}, 1'h0, 16'h0100, 1'h0},
    '{{SYM_J, SYM_K, 5'h1E, 5'h08}, 1'h0, 16'h0080, 1'h1},
    '{{SYM_J, SYM_K, SYM_IDLE, SYM_IDLE}, 1'h0, 16'h0020, 1'h0},
    '{{SYM_J, SYM_K, SYM_IDLE, 5'h1E}, 1'h0, 16'h0000, 1'h0},
    '{{SYM_J, SYM_K, SYM_T, 5'h1E}, 1'h0, 16'h0080, 1'h1},
    '{{SYM_J, SYM_K, SYM_T, SYM_R}, 1'h0, 16'h0000, 1'h0},
    '{{4{SYM_IDLE}}, 1'h1, 16'h0200, 1'h0}};
  logic        clk = 1'h0, rst = 1'h1, sv = 1'h0, pll = 1'h0, sd = 1'h0;
  logic        ane = 1'h0, and_q = 1'h0, rf = 1'h0, lnk = 1'h0, tx = 1'h0;
  logic        r10 = 1'h0, pr = 1'h0, err_seen = 1'h0;
  logic [4:0]  sym = 5'h00, addr;
  logic [15:0] wd, rdat, v;
  logic        wr, rd, rvld, rxe, jab, polc, sqe, lfp, sqi;
  int          n_fail = 0, comparisons = 0;
  // *************************************
  // Clock, design and management model
  // *************************************
  always #2 clk = ~clk;
  always @(posedge clk) if (rxe === 1'h1) err_seen <= 1'h1;
  phy_status_regs #(.JABBER_CYCLES(16)) dut_u (
    .core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rvld),
    .sym_valid_in(sv), .sym_in(sym), .pll_lock_fail_in(pll), .sig_detect_in(sd),
    .rx_err_out(rxe), .an_enable_in(ane), .an_done_in(and_q), .remote_fault_in(rf),
    .link_ok_in(lnk), .tx_en_in(tx), .rx10_active_in(r10), .pol_reversed_in(pr),
    .jabber_out(jab), .pol_correct_out(polc), .sqe_inhibit_out(sqe),
    .link_force_pass_out(lfp), .squelch_inhibit_out(sqi));
  mgmt_model mgmt_u (
    .core_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_wdata_out(wd), .reg_rdata_in(rdat), .reg_rvalid_in(rvld));
  // Word and bit comparisons
  task automatic chk16(input logic [15:0] g, input logic [15:0] x);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t word %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk16({15'h0000, g}, {15'h0000, x});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    cyc(16);
    rst <= 1'h0;
    foreach (ROWS[i]) begin
      cyc(1);
      rst <= 1'h1;
      cyc(1);
      rst <= 1'h0;
      err_seen = 1'h0;
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        sv  <= 1'h1;
        sym <= ROWS[i].s[19-5*k -: 5];
        pll <= ROWS[i].pll;
      end
      @(posedge clk);
      sv  <= 1'h0;
      sym <= ~sym;
      pll <= 1'h0;
      cyc(3);
      mgmt_u.rd_reg(ADDR_XSTAT, v);
      chk16(v, ROWS[i].x);
      chk1(err_seen, ROWS[i].e);
      mgmt_u.rd_reg(ADDR_XSTAT, v);
      chk16(v, 16'h0000);
      $display("Row %0d done", i);
    end
    // Reset value, unmapped read, write masking and controls
    mgmt_u.rd_reg(ADDR_TENOP, v);
    chk16(v, 16'h0010);
    mgmt_u.rd_reg(5'h05, v);
    chk16(v, 16'h0000);
    mgmt_u.wr_reg(ADDR_TENOP, 16'hC02F);
    mgmt_u.rd_reg(ADDR_TENOP, v);
    chk16(v, 16'h003F);
    pr <= 1'h1;
    cyc(3);
    chk16({12'h000, sqe, lfp, sqi, polc}, 16'h000E);
    mgmt_u.wr_reg(ADDR_TENOP, 16'h0000);
    cyc(3);
    chk16({12'h000, sqe, lfp, sqi, polc}, 16'h0001);
    pr <= 1'h0;
    mgmt_u.rd_reg(ADDR_TENOP, v);
    chk16(v, 16'h4010);
    $display("Ops register test done");
    // Transmit jabber with and without inhibit, then remote jabber
    tx <= 1'h1;
    cyc(20);
    chk1(jab, 1'h1);
    tx <= 1'h0;
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    chk16(v & 16'h0004, 16'h0004);
    mgmt_u.wr_reg(ADDR_TENOP, 16'h0020);
    tx <= 1'h1;
    cyc(20);
    chk1(jab, 1'h0);
    tx  <= 1'h0;
    r10 <= 1'h1;
    cyc(20);
    r10 <= 1'h0;
    mgmt_u.rd_reg(ADDR_TENOP, v);
    chk16(v, 16'h8030);
    mgmt_u.rd_reg(ADDR_TENOP, v);
    chk16(v, 16'h0030);
    $display("Jabber test done");
    // Live bits and the basic status mirrors
    lnk <= 1'h1;
    sd  <= 1'h1;
    ane <= 1'h1;
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    chk16(v, 16'h0009);
    and_q <= 1'h1;
    rf    <= 1'h1;
    cyc(1);
    rf <= 1'h0;
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    chk16(v, 16'h001B);
    lnk <= 1'h0;
    sd  <= 1'h0;
    ane <= 1'h0;
    cyc(1);
    lnk <= 1'h1;
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    chk16(v, 16'h0000);
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    chk16(v, 16'h0001);
    // An event on the clearing read edge survives to the next read
    // Failure stands on the edge before the read and on the read edge
    fork
      mgmt_u.rd_reg(ADDR_XSTAT, v);
      begin
        pll <= 1'h1;
        cyc(2);
        pll <= 1'h0;
      end
    join
    chk16(v & 16'h0200, 16'h0200);
    mgmt_u.rd_reg(ADDR_XSTAT, v);
    chk16(v & 16'h0200, 16'h0200);
    $display("Status mirror test done");
    final_report();
  end
endmodule // phy_status_regs_bench
